// *** rtl/system_clock_source_select.sv ***
// system clock source selection, start-up timing and fail monitor
//
// Contract
// - eight modes chosen by three-bit field
// - logic clock mode releases output pin
// - rc clkout mode drives divide-by-4 out
// - rc io mode frees output pin
// - internal clkout drives div4, frees input
// - internal io mode frees both pins
// - internal 8 MHz and 31 kHz sources
// - frequency select picks eight internal rates
// - ext running bit reflects external source
// - ext running resets zero in two-speed/fail
// - hf stable bit shows hf stability
// - lf stable bit shows lf stability
// - select bit routes internal or configured source
// - crystal modes count 1024 input oscillations
// - hold program counter during start count
// - settle delay on source switches in run, none at two-speed hand-over
// - internal sources wait warm-up delay
// - logic clock mode bypasses start count
// - static logic, halt and resume cleanly
// - fail monitor switches to internal oscillator
// - two-speed start runs internal meanwhile
// - hf enabled by nonzero select and scs/two-speed, internal mode or fail
`timescale 1ns/100ps
`default_nettype none

module system_clock_source_select #(
  parameter int START_COUNT  = clk_src_pkg::XTAL_START_COUNT,
  parameter int FAIL_TIMEOUT = clk_src_pkg::FAIL_TIMEOUT
) (
  input  wire logic                   mclk_i,
  input  wire logic                   sys_rst_i,
  input  wire clk_src_pkg::cfg_word_t cfg_i,
  input  wire logic                   wake_i,
  input  wire logic                   osc_in_pin_i,
  input  wire logic [3:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [7:0]                  rdata_o,
  output logic                        sys_clk_en_o,
  output logic                        pc_hold_o,
  output logic                        osc_out_pin_o,
  output logic                        osc_out_oe_n_o,
  output logic                        osc_in_gpio_o,
  output logic                        osc_out_gpio_o,
  output logic                        hf_osc_enable_o,
  output logic                        clock_fail_o
);

  typedef enum logic [4:0] {
    ST_START  = 5'b00001,
    ST_COUNT  = 5'b00010,
    ST_WARM   = 5'b00100,
    ST_RUN    = 5'b01000,
    ST_SWITCH = 5'b10000
  } state_t;

  //////////////////////////////////////////////////////////////////////////////
  // strap capture and mode decode
  logic                   cfg_seen_ff;
  clk_src_pkg::cfg_word_t cfg_ff;
  logic                   is_xtal;
  logic                   is_ext_logic;
  logic                   is_rc;
  logic                   is_external;

  // configuration word caught after reset release
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cfg_seen_ff <= 1'b0;
      cfg_ff      <= '0;
    end else if (!cfg_seen_ff) begin
      cfg_seen_ff <= 1'b1;
      cfg_ff      <= cfg_i;
    end
  end

  // eight modes, six of them external sources
  assign is_xtal      = (cfg_ff.clock_mode_select == clk_src_pkg::MODE_LOW_POWER_XTAL) ||
                        (cfg_ff.clock_mode_select == clk_src_pkg::MODE_MEDIUM_XTAL) ||
                        (cfg_ff.clock_mode_select == clk_src_pkg::MODE_HIGH_GAIN_XTAL);
  assign is_ext_logic = cfg_ff.clock_mode_select == clk_src_pkg::MODE_EXT_LOGIC;
  assign is_rc        = (cfg_ff.clock_mode_select == clk_src_pkg::MODE_RC_IO) ||
                        (cfg_ff.clock_mode_select == clk_src_pkg::MODE_RC_CLKOUT);
  assign is_external  = is_xtal || is_ext_logic || is_rc;

  //////////////////////////////////////////////////////////////////////////////
  // oscillator input synchroniser, three stages
  logic [2:0] osc_sync_ff;
  logic       osc_level_ff;
  logic       osc_rise;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      osc_sync_ff  <= 3'h0;
      osc_level_ff <= 1'b0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_in_pin_i};
      if (osc_sync_ff[1] == osc_sync_ff[2]) begin
        osc_level_ff <= osc_sync_ff[2];
      end
    end
  end

  assign osc_rise = (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2] && !osc_level_ff;

  //////////////////////////////////////////////////////////////////////////////
  // internal oscillator models: dividers from mclk
  logic [15:0] hf_cnt_ff;
  logic        hf_ph_ff;
  logic [15:0] lf_cnt_ff;
  logic        lf_ph_ff;
  logic        hf_tick;
  logic        lf_tick;

  assign hf_tick = (hf_cnt_ff == clk_src_pkg::HF_DIV - 16'h1);
  assign lf_tick = (lf_cnt_ff == clk_src_pkg::LF_DIV - 16'h1);

  // hf half-period divider, runs only while enabled
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !hf_osc_enable_o) begin
      hf_cnt_ff <= 16'h0;
      hf_ph_ff  <= 1'b0;
    end else if (hf_tick) begin
      hf_cnt_ff <= 16'h0;
      hf_ph_ff  <= !hf_ph_ff;
    end else begin
      hf_cnt_ff <= hf_cnt_ff + 16'h1;
    end
  end

  // lf half-period divider, always running
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lf_cnt_ff <= 16'h0;
      lf_ph_ff  <= 1'b0;
    end else if (lf_tick) begin
      lf_cnt_ff <= 16'h0;
      lf_ph_ff  <= !lf_ph_ff;
    end else begin
      lf_cnt_ff <= lf_cnt_ff + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register
  logic [2:0] freq_sel_ff;
  logic       scs_ff;
  logic       fail_ff;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      freq_sel_ff <= clk_src_pkg::INTERNAL_FREQ_SELECT_RESET;
      scs_ff      <= 1'b0;
    end else if (wr_i && addr_i == clk_src_pkg::OSC_CTRL_ADDR) begin
      freq_sel_ff <= wdata_i[clk_src_pkg::INTERNAL_FREQ_SELECT_LSB +: 3];
      scs_ff      <= wdata_i[clk_src_pkg::SCS_BIT];
    end
  end

  // hf enable: nonzero select with scs or two-speed, or nonzero select while the
  // internal source is the configured one or has taken over after a fail
  assign hf_osc_enable_o = (freq_sel_ff != clk_src_pkg::INTERNAL_FREQ_SELECT_LF) &&
                           (scs_ff || cfg_ff.two_speed_enable ||
                            !is_external || fail_ff);

  // postscaler: 8 MHz divided by 2^(7-sel); sel 000 picks lf phase
  logic [6:0] post_cnt_ff;
  logic       hf_rise;
  logic       int_tick;
  logic [2:0] post_shift;

  assign hf_rise    = hf_tick && !hf_ph_ff;
  assign post_shift = clk_src_pkg::INTERNAL_FREQ_SELECT_8MHZ - freq_sel_ff;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      post_cnt_ff <= 7'h0;
    end else if (hf_rise) begin
      post_cnt_ff <= post_cnt_ff + 7'h1;
    end
  end

  always_comb begin
    if (freq_sel_ff == clk_src_pkg::INTERNAL_FREQ_SELECT_LF) begin
      int_tick = lf_tick && !lf_ph_ff;
    end else begin
      int_tick = hf_rise && ((post_cnt_ff & ((7'h1 << post_shift) - 7'h1)) == 7'h0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stability flags
  logic [7:0] hf_warm_ff;
  logic       lf_stable_ff;

  // hf stable after warm-up, lost when disabled
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !hf_osc_enable_o) begin
      hf_warm_ff <= 8'h0;
    end else if (hf_warm_ff != 8'(clk_src_pkg::WARMUP_CYCLES)) begin
      hf_warm_ff <= hf_warm_ff + 8'h1;
    end
  end

  // lf stable after its first full period
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lf_stable_ff <= 1'b0;
    end else if (lf_tick && lf_ph_ff) begin
      lf_stable_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock fail monitor: no input edge within timeout
  logic [11:0] fail_cnt_ff;
  logic        is_xtal_starting;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || osc_rise) begin
      fail_cnt_ff <= 12'h0;
    end else if (lf_tick && fail_cnt_ff != 12'(FAIL_TIMEOUT)) begin
      fail_cnt_ff <= fail_cnt_ff + 12'h1;
    end
  end

  // sticky fail flag, set wins over write-one-to-clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fail_ff <= 1'b0;
    end else if (cfg_ff.clock_fail_enable && is_external && !is_xtal_starting &&
                 fail_cnt_ff == 12'(FAIL_TIMEOUT)) begin
      fail_ff <= 1'b1;
    end else if (wr_i && addr_i == clk_src_pkg::OSC_STATUS_ADDR &&
                 wdata_i[clk_src_pkg::FAIL_BIT]) begin
      fail_ff <= 1'b0;
    end
  end

  assign clock_fail_o = fail_ff;

  //////////////////////////////////////////////////////////////////////////////
  // source state machine
  state_t      state_ff;
  logic [10:0] start_cnt_ff;
  logic        use_ext_ff;
  logic        want_ext;
  logic [1:0]  settle_ff;
  logic        wake_seen_ff;

  assign is_xtal_starting = (state_ff == ST_COUNT);

  // external wanted when configured, scs clear and no failure
  assign want_ext = is_external && !scs_ff && !fail_ff;

  // wake from sleep restarts the start-up sequence
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wake_seen_ff <= 1'b0;
    end else begin
      wake_seen_ff <= wake_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_ff     <= ST_START;
      start_cnt_ff <= 11'h0;
      use_ext_ff   <= 1'b0;
      settle_ff    <= 2'h0;
    end else if (wake_i && !wake_seen_ff) begin
      state_ff     <= ST_START;
      start_cnt_ff <= 11'h0;
    end else begin
      case (state_ff)
        ST_START: begin
          if (!cfg_seen_ff) begin
            state_ff <= ST_START;
          end else if (is_xtal && !scs_ff) begin
            state_ff <= ST_COUNT;
          end else if (is_external && !scs_ff) begin
            use_ext_ff <= 1'b1;   // no start count
            state_ff   <= ST_RUN;
          end else begin
            state_ff <= ST_WARM;
          end
        end
        ST_COUNT: begin
          if (osc_rise) begin
            start_cnt_ff <= start_cnt_ff + 11'h1;
          end
          if (start_cnt_ff == 11'(START_COUNT)) begin
            use_ext_ff <= want_ext;
            state_ff   <= ST_RUN;
          end else if (scs_ff || fail_ff) begin
            state_ff <= ST_WARM;
          end
        end
        ST_WARM: begin
          if ((freq_sel_ff == clk_src_pkg::INTERNAL_FREQ_SELECT_LF) ? lf_stable_ff
                : (hf_warm_ff == 8'(clk_src_pkg::WARMUP_CYCLES))) begin
            use_ext_ff <= 1'b0;
            state_ff   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (want_ext != use_ext_ff) begin
            settle_ff <= 2'h0;
            state_ff  <= ST_SWITCH;
          end
        end
        ST_SWITCH: begin
          // count internal clock edges while the external input is low, then swap
          if (!osc_level_ff && int_tick) begin
            settle_ff <= settle_ff + 2'h1;
          end
          if (settle_ff == 2'(clk_src_pkg::SETTLE_EDGES)) begin
            use_ext_ff <= want_ext;
            state_ff   <= ST_RUN;
          end else if (want_ext == use_ext_ff) begin
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_START;
      endcase
    end
  end

  // two-speed: internal clock runs code during the crystal count
  logic run_internal;
  assign run_internal = is_xtal_starting && cfg_ff.two_speed_enable;

  // hold execution during start count unless two-speed
  assign pc_hold_o = (state_ff == ST_START) || (state_ff == ST_WARM) ||
                     (is_xtal_starting && !cfg_ff.two_speed_enable);

  // system clock enable; no edge means full halt with state kept
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sys_clk_en_o <= 1'b0;
    end else if (state_ff == ST_RUN || state_ff == ST_SWITCH) begin
      sys_clk_en_o <= use_ext_ff ? osc_rise : int_tick;
    end else begin
      sys_clk_en_o <= run_internal && int_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock out pin: divide the running clock by 4
  logic [1:0] div4_ff;
  logic       clkout_mode;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div4_ff <= 2'h0;
    end else if (sys_clk_en_o) begin
      div4_ff <= div4_ff + 2'h1;
    end
  end

  assign clkout_mode = (cfg_ff.clock_mode_select == clk_src_pkg::MODE_RC_CLKOUT) ||
                       (cfg_ff.clock_mode_select == clk_src_pkg::MODE_INTERNAL_CLKOUT);

  // pin roles by mode
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      osc_out_pin_o  <= 1'b0;
      osc_out_oe_n_o <= 1'b1;
      osc_out_gpio_o <= 1'b0;
      osc_in_gpio_o  <= 1'b0;
    end else begin
      osc_out_pin_o  <= clkout_mode && div4_ff[1];
      osc_out_oe_n_o <= !clkout_mode;
      osc_out_gpio_o <= is_ext_logic || is_rc && !clkout_mode ||
                        cfg_ff.clock_mode_select == clk_src_pkg::MODE_INTERNAL_IO;
      osc_in_gpio_o  <= cfg_ff.clock_mode_select == clk_src_pkg::MODE_INTERNAL_IO ||
                        cfg_ff.clock_mode_select == clk_src_pkg::MODE_INTERNAL_CLKOUT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read port, data the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h0;
    end else if (rd_i && addr_i == clk_src_pkg::OSC_CTRL_ADDR) begin
      rdata_o <= {1'b0, freq_sel_ff, use_ext_ff && state_ff != ST_COUNT,
                  hf_warm_ff == 8'(clk_src_pkg::WARMUP_CYCLES),
                  lf_stable_ff, scs_ff};
    end else if (rd_i && addr_i == clk_src_pkg::OSC_STATUS_ADDR) begin
      rdata_o <= {7'h0, fail_ff};
    end else begin
      rdata_o <= 8'h0;
    end
  end

endmodule // system_clock_source_select

`default_nettype wire

// *** rtl/clk_src_pkg.sv ***
// constants and types shared by the system clock source selection logic
package clk_src_pkg;

  // clock mode encodings of the three-bit configuration field
  localparam logic [2:0] MODE_LOW_POWER_XTAL  = 3'h0;
  localparam logic [2:0] MODE_MEDIUM_XTAL     = 3'h1;
  localparam logic [2:0] MODE_HIGH_GAIN_XTAL  = 3'h2;
  localparam logic [2:0] MODE_EXT_LOGIC       = 3'h3;
  localparam logic [2:0] MODE_INTERNAL_IO     = 3'h4;
  localparam logic [2:0] MODE_INTERNAL_CLKOUT = 3'h5;
  localparam logic [2:0] MODE_RC_IO           = 3'h6;
  localparam logic [2:0] MODE_RC_CLKOUT       = 3'h7;

  // register offsets and field positions
  localparam logic [3:0] OSC_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] OSC_STATUS_ADDR = 4'h1;
  localparam int         SCS_BIT         = 0;
  localparam int         LTS_BIT         = 1;
  localparam int         HTS_BIT         = 2;
  localparam int         EXT_CLOCK_RUNNING_BIT        = 3;
  localparam int         INTERNAL_FREQ_SELECT_LSB        = 4;
  localparam int         FAIL_BIT        = 0;

  // frequency select reset value and encodings
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h6;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_LF    = 3'h0;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_8MHZ  = 3'h7;

  // timing
  localparam int          MCLK_HZ          = 25000000;
  localparam int          HF_HZ            = 8000000;
  localparam int          LF_HZ            = 31000;
  localparam int          XTAL_START_COUNT = 1024;
  localparam int          WARMUP_NS        = 2000;
  localparam int          WARMUP_CYCLES    = (WARMUP_NS * (MCLK_HZ / 1000000) + 999) / 1000;
  localparam int          SETTLE_EDGES     = 2;
  localparam int          FAIL_TIMEOUT     = 2048;
  localparam logic [15:0] HF_DIV           = 16'(MCLK_HZ / HF_HZ / 2);
  localparam logic [15:0] LF_DIV           = 16'(MCLK_HZ / LF_HZ / 2);

  // configuration word straps
  typedef struct packed {
    logic [2:0] clock_mode_select;
    logic       two_speed_enable;
    logic       clock_fail_enable;
    logic       powerup_timer_enable;
  } cfg_word_t;

  // bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

endpackage

// *** bench/clk_src_props.sv ***
// port assertions for the system clock source selection block
`timescale 1ns/100ps
`default_nettype none

module clk_src_props #(
  parameter int START_COUNT  = 8,
  parameter int FAIL_TIMEOUT = 8
) (
  input wire logic                   mclk_i,
  input wire logic                   sys_rst_i,
  input wire clk_src_pkg::cfg_word_t cfg_i,
  input wire logic                   wake_i,
  input wire logic                   osc_in_pin_i,
  input wire logic [3:0]             addr_i,
  input wire logic [7:0]             wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   sys_clk_en_o,
  input wire logic                   pc_hold_o,
  input wire logic                   osc_out_pin_o,
  input wire logic                   osc_out_oe_n_o,
  input wire logic                   osc_in_gpio_o,
  input wire logic                   osc_out_gpio_o,
  input wire logic                   hf_osc_enable_o,
  input wire logic                   clock_fail_o
);
  logic [2:0] run_cnt_ff;
  logic       settled;
  logic [2:0] mode;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // cycles since reset release, saturating; pins judged once running
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) run_cnt_ff <= 3'h0;
    else if (run_cnt_ff != 3'h7) run_cnt_ff <= run_cnt_ff + 3'h1;
  end
  assign settled = (run_cnt_ff == 3'h7) && !pc_hold_o;
  assign mode    = cfg_i.clock_mode_select;

  ////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_CTRL_BIT7: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |-> !rdata_o[7])
    else $error("unused control bit reads one");
  AST_HF_ENABLE: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |->
      $past(hf_osc_enable_o) == (rdata_o[6:4] != 3'h0 && (rdata_o[0] || cfg_i.two_speed_enable ||
      mode inside {3'h4, 3'h5} || $past(clock_fail_o))))
    else $error("hf enable disagrees with select fields");
  AST_PIN_XTAL: assert property (settled && mode < 3'h3 |-> !osc_in_gpio_o && !osc_out_gpio_o)
    else $error("crystal pins freed");
  AST_PIN_EXT: assert property (settled && mode == 3'h3 |-> osc_out_gpio_o && osc_out_oe_n_o)
    else $error("logic clock mode keeps output pin");
  AST_PIN_IO: assert property (settled && mode == 3'h4 |->
      osc_in_gpio_o && osc_out_gpio_o && osc_out_oe_n_o)
    else $error("internal io mode keeps a pin");
  AST_PIN_INTCLK: assert property (settled && mode == 3'h5 |-> !osc_out_oe_n_o && osc_in_gpio_o)
    else $error("internal clkout pins wrong");
  AST_PIN_RC_IO_MODE: assert property (settled && mode == 3'h6 |->
      osc_out_gpio_o && osc_out_oe_n_o && !osc_in_gpio_o)
    else $error("rc io pins wrong");
  AST_PIN_RCCLK: assert property (settled && mode == 3'h7 |-> !osc_out_oe_n_o && !osc_out_gpio_o)
    else $error("rc clkout pin not driven");
  AST_FAIL_STICKY: assert property (clock_fail_o && !(wr_i && addr_i == 4'h1 && wdata_i[0])
      |=> clock_fail_o)
    else $error("fail flag dropped without clear");
  AST_RESET_VALS: assert property ($fell(sys_rst_i) |-> osc_out_oe_n_o && !sys_clk_en_o
      && rdata_o == 8'h00 && !clock_fail_o)
    else $error("outputs not at reset values");
endmodule // clk_src_props

bind system_clock_source_select clk_src_props #(
  .START_COUNT(START_COUNT), .FAIL_TIMEOUT(FAIL_TIMEOUT)
) i_props (
  .mclk_i, .sys_rst_i, .cfg_i, .wake_i, .osc_in_pin_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .sys_clk_en_o, .pc_hold_o, .osc_out_pin_o, .osc_out_oe_n_o, .osc_in_gpio_o,
  .osc_out_gpio_o, .hf_osc_enable_o, .clock_fail_o
);

`default_nettype wire

// *** bench/ext_osc_model.sv ***
// behavioural external clock source feeding the oscillator input pin
`timescale 1ns/100ps
`default_nettype none

module ext_osc_model #(
  parameter real HALF_NS = 70.0
) (
  input  wire logic run_i,
  input  wire logic slow_i,
  output var  logic osc_o
);
  // toggles while running, slow doubles the period, parked low when stopped
  initial begin
    osc_o = 1'b0;
    forever begin
      if (run_i) begin
        #(slow_i ? 2.0 * HALF_NS : HALF_NS) osc_o = ~osc_o;
      end else begin
        osc_o = 1'b0;
        @(run_i);
      end
    end
  end
endmodule // ext_osc_model

`default_nettype wire

// *** bench/system_clock_source_select_bench.sv ***
// self-checking bench for the system clock source selection block
`timescale 1ns/100ps
`default_nettype none

module system_clock_source_select_bench;
  localparam int START = 8;
  typedef struct packed {
    logic [2:0] pins;
    logic [2:0] mask;
    logic       xtal;
    logic       ext_run;
  } row_t;
  logic                   mclk_i, sys_rst_i, wake_i, wr_i, rd_i, osc_in_pin_i, osc_run, osc_slow;
  clk_src_pkg::cfg_word_t cfg_i;
  logic [3:0]             addr_i;
  logic [7:0]             wdata_i, rdata_o, rd_val;
  logic                   sys_clk_en_o, pc_hold_o, osc_out_pin_o, osc_out_oe_n_o;
  logic                   osc_in_gpio_o, osc_out_gpio_o, hf_osc_enable_o, clock_fail_o;
  int                     n_fail, n_checks, rises, cyc, ticks, n;
  row_t                   rows [8];

  system_clock_source_select #(.START_COUNT(START), .FAIL_TIMEOUT(8)) i_dut (
    .mclk_i, .sys_rst_i, .cfg_i, .wake_i, .osc_in_pin_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .sys_clk_en_o, .pc_hold_o, .osc_out_pin_o, .osc_out_oe_n_o, .osc_in_gpio_o,
    .osc_out_gpio_o, .hf_osc_enable_o, .clock_fail_o
  );
  ext_osc_model i_osc (.run_i(osc_run), .slow_i(osc_slow), .osc_o(osc_in_pin_i));

  // 25 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    rd_val = rdata_o;
  endtask
  task automatic do_reset(input logic [2:0] m, input logic fail_en, input logic two);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    cfg_i     <= '{m, two, fail_en, 1'b0};
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
  endtask
  // counts input pin rises and cycles until execution is released
  task automatic measure();
    logic last;
    rises = 0;
    cyc   = 0;
    last  = osc_in_pin_i;
    while (pc_hold_o !== 1'b0 || cyc < 6) begin
      @(negedge mclk_i);
      rises += int'(osc_in_pin_i & ~last);
      last = osc_in_pin_i;
      cyc++;
      if (cyc > 5000) begin
        check(8'h00, 8'h01);
        results();
      end
    end
  endtask
  task automatic wait_out(input logic v);
    int k;
    k = 0;
    do begin
      @(negedge mclk_i);
      ticks += int'(sys_clk_en_o === 1'b1);
      k++;
      if (k > 2000) begin
        check(8'h00, 8'h01);
        results();
      end
    end while (osc_out_pin_o !== v);
  endtask
  task automatic count_ticks(input int c);
    ticks = 0;
    repeat (c) @(negedge mclk_i) ticks += int'(sys_clk_en_o === 1'b1);
  endtask
  task automatic poll_ext(input logic v);
    int k;
    k = 0;
    do begin
      bus_rd(4'h0);
      k++;
    end while (rd_val[3] !== v && k < 200);
    check(8'(rd_val[3]), 8'(v));
    if (rd_val[3] !== v) results();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: one row per clock mode, then the awkward cases
  initial begin
    sys_rst_i = 1'b1;
    cfg_i     = '0;
    wake_i    = 1'b0;
    addr_i    = 4'h0;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    osc_run   = 1'b1;
    osc_slow  = 1'b0;
    n_fail    = 0;
    n_checks  = 0;
    // {in gpio, out gpio, out oe_n}, compare mask, crystal, runs external
    rows = '{'{3'b000, 3'b110, 1'b1, 1'b1}, '{3'b000, 3'b110, 1'b1, 1'b1},
             '{3'b000, 3'b110, 1'b1, 1'b1}, '{3'b011, 3'b111, 1'b0, 1'b1},
             '{3'b111, 3'b111, 1'b0, 1'b0}, '{3'b100, 3'b111, 1'b0, 1'b0},
             '{3'b011, 3'b111, 1'b0, 1'b1}, '{3'b000, 3'b111, 1'b0, 1'b1}};
    for (int i = 0; i < 8; i++) begin
      osc_slow = (i == 6);
      do_reset(3'(i), 1'b0, 1'b0);
      measure();
      if (rows[i].xtal) check(8'(rises >= START), 8'h01);
      else if (rows[i].ext_run) check(8'(rises < START), 8'h01);
      else check(8'(cyc >= clk_src_pkg::WARMUP_CYCLES), 8'h01);
      repeat (4) @(posedge mclk_i);
      bus_rd(4'h0);
      check(rd_val & 8'hf9, {4'h6, rows[i].ext_run, 3'b000});
      check(8'({osc_in_gpio_o, osc_out_gpio_o, osc_out_oe_n_o} & rows[i].mask),
            8'(rows[i].pins & rows[i].mask));
      if (rows[i].mask[0] && !rows[i].pins[0]) begin
        wait_out(1'b0);
        wait_out(1'b1);
        ticks = 0;
        wait_out(1'b0);
        wait_out(1'b1);
        check(8'(ticks), 8'h04);
      end
      if (rows[i].xtal) begin
        @(posedge mclk_i);
        wake_i <= 1'b1;
        @(posedge mclk_i);
        wake_i <= 1'b0;
        measure();
        check(8'(rises >= START), 8'h01);
      end
    end
    // frequency select, read-only bits, system clock select
    osc_slow = 1'b0;
    do_reset(clk_src_pkg::MODE_EXT_LOGIC, 1'b0, 1'b0);
    measure();
    for (int f = 0; f < 16; f++) begin
      bus_wr(4'h0, {1'b1, 3'(f >> 1), 3'b111, f[0]});
      bus_rd(4'h0);
      check(rd_val & 8'hf1, {1'b0, 3'(f >> 1), 3'b000, f[0]});
      check(8'(hf_osc_enable_o), 8'(((f >> 1) != 0) && f[0]));
    end
    poll_ext(1'b0);
    bus_wr(4'h0, 8'h60);
    poll_ext(1'b1);
    bus_wr(4'hf, 8'hff);
    bus_rd(4'hf);
    check(rd_val, 8'h00);
    // stopping the external clock halts, restarting resumes
    @(posedge mclk_i);
    osc_run <= 1'b0;
    repeat (10) @(posedge mclk_i);
    count_ticks(100);
    check(8'(ticks), 8'h00);
    osc_run <= 1'b1;
    count_ticks(100);
    check(8'(ticks > 0), 8'h01);
    bus_rd(4'h0);
    check(rd_val & 8'hf9, 8'h68);
    check(rd_val & 8'h04, 8'h00);
    // two-speed start with a dead crystal runs from the internal source
    osc_run = 1'b0;
    do_reset(clk_src_pkg::MODE_MEDIUM_XTAL, 1'b0, 1'b1);
    measure();
    bus_rd(4'h0);
    check(rd_val & 8'h08, 8'h00);
    count_ticks(100);
    check(8'(ticks > 0), 8'h01);
    osc_run = 1'b1;
    poll_ext(1'b1);
    // fail monitor catches a stopped external clock
    do_reset(clk_src_pkg::MODE_EXT_LOGIC, 1'b1, 1'b0);
    bus_rd(4'h0);
    check(rd_val & 8'h08, 8'h00);
    measure();
    @(posedge mclk_i);
    osc_run <= 1'b0;
    n = 0;
    while (clock_fail_o !== 1'b1 && n < 30000) begin
      @(negedge mclk_i);
      n++;
    end
    check(8'(clock_fail_o), 8'h01);
    if (clock_fail_o !== 1'b1) results();
    poll_ext(1'b0);
    bus_rd(4'h1);
    check(rd_val & 8'h01, 8'h01);
    count_ticks(200);
    check(8'(ticks > 0), 8'h01);
    bus_rd(4'h0);
    check(rd_val & 8'h06, 8'h06);
    results();
  end
endmodule // system_clock_source_select_bench

`default_nettype wire
